/* File: ddrcr_calib_readout.sv */
// Calibration-pattern readout: command decode, mode state, lane fill, AHB-Lite registers
//
// Overview of operation
// - Mode set to register three with bit 2 high enables readout mode.
// - In readout mode every column read is served from the readout register.
// - Reset stays honoured in readout mode and returns device to reset state.
// - In readout mode read with autoprecharge acts as plain read, no precharge.
// - With readout disabled, reads and writes go to array; location ignored.
// - Location 00 returns calibration pattern; 01, 10, 11 are reserved.
// - Eight-beat burst delivers 0,1,0,1,0,1,0,1 in order 0 to 7, or 4 to 7 then 0 to 3 with column bit 2 high.
// - Four-beat chop picks nibble by column bit 2; pattern 0,1,0,1 either way.
// - Readout value on lane 0; other lanes carry same value or zero.
// - Bit 0 of both bytes carries the value; other bits replicate or zero.
// - Bank bits, autoprecharge bit and other column bits ignored for readout reads.
// - Burst chop honoured on the fly and when fixed by mode setting.
// - Readout data use the same read latency as array reads.
// - Burst order bit 0 goes first, bit 7 last; with column bit 2 high bit 4 goes first, bit 3 last.
// - Pattern burst starts after read latency, additive plus column access latency.
`timescale 1ns/1ps
`default_nettype none

module ddrcr_calib_readout import ddrcr_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Memory command pins
	input var ddrcr_cmd_bus_t cmd,
	input wire logic ddr_reset_n,
	// Data lanes
	output logic [DQ_WIDTH-1:0] dq_out,
	output logic dq_oe,
	// Array side
	output logic array_rd_q,
	output logic array_wr_q,
	output logic array_autopre_q,
	output logic [2:0] array_ba_q,
	output logic [15:0] array_col_q
);

	// ==========================================================
	// Command decode
	function automatic ddrcr_cmd_t decode_cmd(input ddrcr_cmd_bus_t c);
		if (c.cs_n)
			decode_cmd = CMD_NOP;
		else if (!c.ras_n && !c.cas_n && !c.we_n)
			decode_cmd = CMD_MODE_SET;
		else if (c.ras_n && !c.cas_n && c.we_n)
			decode_cmd = CMD_READ;
		else if (c.ras_n && !c.cas_n && !c.we_n)
			decode_cmd = CMD_WRITE;
		else
			decode_cmd = CMD_NOP;
	endfunction

	// Fixed modes ignore the chop bit; reserved code behaves as eight beats
	function automatic logic chop_sel(input logic [1:0] bm, input logic bc_bit);
		if (bm == BL_FIXED4)
			chop_sel = 1'b1;
		else if (bm == BL_ON_FLY)
			chop_sel = !bc_bit;
		else
			chop_sel = 1'b0;
	endfunction

	// ==========================================================
	// Register select, shared by the read mux and the write strobe
	function automatic logic is_ctrl(input logic [11:0] a);
		is_ctrl = (a == DDRCR_ADDR_CTRL);
	endfunction

	ddrcr_cmd_t cmd_kind;
	ddrcr_state_t state_q;
	logic [1:0] loc_q;
	logic [1:0] burst_mode_q;
	logic [7:0] readout_cnt_q;
	logic [4:0] cl_q;
	logic [1:0] al_q;
	logic repl_q;
	logic [4:0] al_cycles;
	logic [4:0] rl;
	logic launch;
	ddrcr_burst_t launch_req;
	logic beat_valid;
	logic beat_bit;
	logic pipe_busy;
	logic mode_three_set;
	logic mode_zero_set;

	assign cmd_kind = decode_cmd(cmd);
	assign mode_three_set = (cmd_kind == CMD_MODE_SET) && (cmd.ba == BA_MODE_THREE);
	assign mode_zero_set = (cmd_kind == CMD_MODE_SET) && (cmd.ba == BA_MODE_ZERO);

	// ==========================================================
	// Mode register three state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_NORMAL;
			loc_q <= LOC_PATTERN;
		end else if (!ddr_reset_n) begin
			state_q <= ST_NORMAL;
			loc_q <= LOC_PATTERN;
		end else if (mode_three_set) begin
			state_q <= cmd.addr[A_READOUT_EN] ? ST_READOUT : ST_NORMAL;
			loc_q <= cmd.addr[A_LOC_LSB +: 2];
		end
	end

	// Burst length field of mode register zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			burst_mode_q <= MODE_RST;
		end else if (!ddr_reset_n) begin
			burst_mode_q <= MODE_RST;
		end else if (mode_zero_set) begin
			burst_mode_q <= cmd.addr[A_BL_LSB +: 2];
		end
	end

	// ==========================================================
	// Read routing
	always_comb begin
		launch = 1'b0;
		unique case (state_q)
			ST_NORMAL: launch = 1'b0;
			// A read that meets a memory reset is dropped with the mode
			ST_READOUT: launch = (cmd_kind == CMD_READ) && ddr_reset_n;
		endcase
	end

	// Only bit 2 and the chop bit steer the burst; bank and other bits unused
	assign launch_req.chop = chop_sel(burst_mode_q, cmd.addr[A_BURST_CHOP]);
	assign launch_req.nibble = cmd.addr[A_NIBBLE];
	assign launch_req.loc = loc_q;

	// Array accesses only in normal state; a readout read never precharges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			array_rd_q <= 1'b0;
			array_wr_q <= 1'b0;
			array_autopre_q <= 1'b0;
		end else begin
			array_rd_q <= (state_q == ST_NORMAL) && (cmd_kind == CMD_READ);
			array_wr_q <= (state_q == ST_NORMAL) && (cmd_kind == CMD_WRITE);
			array_autopre_q <= (state_q == ST_NORMAL) && (cmd_kind == CMD_READ ||
				cmd_kind == CMD_WRITE) && cmd.addr[A_AUTOPRE];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			array_ba_q <= 3'h0;
			array_col_q <= 16'h0000;
		end else if (state_q == ST_NORMAL && (cmd_kind == CMD_READ || cmd_kind == CMD_WRITE)) begin
			array_ba_q <= cmd.ba;
			array_col_q <= cmd.addr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			readout_cnt_q <= 8'h00;
		end else if (!ddr_reset_n) begin
			readout_cnt_q <= 8'h00;
		end else if (launch) begin
			readout_cnt_q <= readout_cnt_q + 8'h01;
		end
	end

	// ==========================================================
	// Read latency, shared with array reads
	always_comb begin
		if (al_q == AL_CL_MINUS1)
			al_cycles = cl_q - 5'h01;
		else if (al_q == AL_CL_MINUS2)
			al_cycles = cl_q - 5'h02;
		else
			al_cycles = 5'h00;
	end

	// Limitation: sums above 31 wrap; keep latency settings realistic
	assign rl = al_cycles + cl_q;

	ddrcr_lat_pipe u_pipe (
		.hclk(hclk),
		.hresetn(hresetn),
		.launch(launch),
		.launch_req(launch_req),
		.rl(rl),
		.beat_valid_q(beat_valid),
		.beat_bit_q(beat_bit),
		.busy(pipe_busy)
	);

	// ==========================================================
	// Lane fill: byte bit 0 always carries the value
	genvar ln;
	generate
		for (ln = 0; ln < DQ_WIDTH; ln++) begin : g_lane
			if (ln % LANES_PER_BYTE == 0) begin : g_carry
				assign dq_out[ln] = beat_bit;
			end else begin : g_fill
				assign dq_out[ln] = repl_q & beat_bit;
			end
		end
	endgenerate

	assign dq_oe = beat_valid;

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic addr_ok;
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [31:0] status_word;
	logic [31:0] ctrl_word;
	logic ctrl_wr;

	assign addr_ok = hsel && hready && htrans[1];
	// Control write lands at the end of its data phase
	assign ctrl_wr = wr_pend_q && is_ctrl(wr_addr_q);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		ctrl_word = 32'h0000_0000;
		// A read right behind a control write must see the word being written
		if (ctrl_wr) begin
			ctrl_word[CTRL_CL_LSB +: 5] = hwdata[CTRL_CL_LSB +: 5];
			ctrl_word[CTRL_AL_LSB +: 2] = hwdata[CTRL_AL_LSB +: 2];
			ctrl_word[CTRL_REPL_BIT] = hwdata[CTRL_REPL_BIT];
		end else begin
			ctrl_word[CTRL_CL_LSB +: 5] = cl_q;
			ctrl_word[CTRL_AL_LSB +: 2] = al_q;
			ctrl_word[CTRL_REPL_BIT] = repl_q;
		end
		status_word = 32'h0000_0000;
		status_word[STAT_EN_BIT] = (state_q == ST_READOUT);
		status_word[STAT_LOC_LSB +: 2] = loc_q;
		status_word[STAT_BM_LSB +: 2] = burst_mode_q;
		status_word[STAT_BUSY_BIT] = pipe_busy;
		status_word[STAT_CNT_LSB +: 8] = readout_cnt_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[11:0];
		end
	end

	// Read data captured in the address phase so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			// Unmapped offsets read as zero
			if (is_ctrl(haddr[11:0]))
				hrdata <= ctrl_word;
			else if (haddr[11:0] == DDRCR_ADDR_STATUS)
				hrdata <= status_word;
			else
				hrdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cl_q <= CTRL_CL_RST;
			al_q <= CTRL_AL_RST;
			repl_q <= CTRL_REPL_RST;
		end else if (ctrl_wr) begin
			cl_q <= hwdata[CTRL_CL_LSB +: 5];
			al_q <= hwdata[CTRL_AL_LSB +: 2];
			repl_q <= hwdata[CTRL_REPL_BIT];
		end
	end

endmodule

`default_nettype wire

/* File: ddrcr_calib_readout_assertions.sv */
// Port-level checks of the calibration-pattern readout block
`timescale 1ns/1ps
`default_nettype none
module ddrcr_calib_readout_assertions import ddrcr_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Command pins
	input var ddrcr_cmd_bus_t cmd,
	input wire logic ddr_reset_n,
	// Data lanes
	input wire logic [DQ_WIDTH-1:0] dq_out,
	input wire logic dq_oe,
	// Array side
	input wire logic array_rd_q,
	input wire logic array_wr_q,
	input wire logic array_autopre_q,
	input wire logic [2:0] array_ba_q,
	input wire logic [15:0] array_col_q
);
	// ====
	// Command decode and a mirror of the readout enable
	logic sel_c, rd_c, wr_c, ms_c, mode_q;
	assign sel_c = !cmd.cs_n && !cmd.cas_n;
	assign rd_c = sel_c && cmd.ras_n && cmd.we_n;
	assign wr_c = sel_c && cmd.ras_n && !cmd.we_n;
	assign ms_c = sel_c && !cmd.ras_n && !cmd.we_n;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= 1'b0;
		end else if (!ddr_reset_n) begin
			mode_q <= 1'b0;
		end else if (ms_c && cmd.ba == BA_MODE_THREE) begin
			mode_q <= cmd.addr[A_READOUT_EN];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====
	// Properties
	sequence s_ro_read;
		ddr_reset_n && mode_q && rd_c;
	endsequence
	sequence s_mem_reset_read;
		!ddr_reset_n ##1 (ddr_reset_n && rd_c);
	endsequence
	property p_ro_no_array; s_ro_read |=> !array_rd_q; endproperty
	a_ro_no_array: assert property (p_ro_no_array)
		else $error("readout read reached the array");
	property p_ro_no_pre; s_ro_read ##0 cmd.addr[A_AUTOPRE] |=> !array_autopre_q; endproperty
	a_ro_no_pre: assert property (p_ro_no_pre)
		else $error("autoprecharge during readout");
	property p_norm_read;
		ddr_reset_n && !mode_q && rd_c |=> array_rd_q && array_col_q[9:0] == $past(cmd.addr[9:0]);
	endproperty
	a_norm_read: assert property (p_norm_read)
		else $error("normal read missed the array");
	property p_norm_write; ddr_reset_n && !mode_q && wr_c |=> array_wr_q; endproperty
	a_norm_write: assert property (p_norm_write)
		else $error("normal write missed the array");
	property p_norm_addr;
		ddr_reset_n && !mode_q && (rd_c || wr_c) |=> array_ba_q == $past(cmd.ba) &&
			array_autopre_q == $past(cmd.addr[A_AUTOPRE]);
	endproperty
	a_norm_addr: assert property (p_norm_addr)
		else $error("array bank or precharge not passed on");
	property p_quiet; !rd_c && !wr_c |=> !array_rd_q && !array_wr_q; endproperty
	a_quiet: assert property (p_quiet)
		else $error("array access without a command");
	property p_mem_reset; s_mem_reset_read |=> array_rd_q; endproperty
	a_mem_reset: assert property (p_mem_reset)
		else $error("memory reset left readout mode on");
	property p_lane_fill;
		dq_oe |-> dq_out[7:1] == {7{dq_out[0]}} || dq_out[7:1] == 7'h00;
	endproperty
	a_lane_fill: assert property (p_lane_fill)
		else $error("lower lanes neither copy nor zero");
	property p_upper; dq_oe |-> dq_out[15:8] == dq_out[7:0]; endproperty
	a_upper: assert property (p_upper)
		else $error("upper byte differs from lower byte");
	property p_first_zero; $rose(dq_oe) |-> !dq_out[0]; endproperty
	a_first_zero: assert property (p_first_zero)
		else $error("burst does not start with zero");
	property p_min_beats; $rose(dq_oe) |-> dq_oe[*4]; endproperty
	a_min_beats: assert property (p_min_beats)
		else $error("burst shorter than four beats");
endmodule
bind ddrcr_calib_readout ddrcr_calib_readout_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
	.cmd(cmd), .ddr_reset_n(ddr_reset_n), .dq_out(dq_out), .dq_oe(dq_oe),
	.array_rd_q(array_rd_q), .array_wr_q(array_wr_q), .array_autopre_q(array_autopre_q),
	.array_ba_q(array_ba_q), .array_col_q(array_col_q));
`default_nettype wire

/* File: ddrcr_ctrl_model.sv */
// Memory controller model on the command pins; banks idle, delay-locked loop locked
`timescale 1ns/1ps
`default_nettype none
module ddrcr_ctrl_model import ddrcr_pkg::*; #(
	parameter int T_MOD = 12,
	parameter int T_MPRR = 2
) (
	// Clock
	input wire logic hclk,
	// Command pins
	output var ddrcr_cmd_bus_t cmd,
	output logic ddr_reset_n
);
	initial begin
		cmd = {4'hf, 3'h0, 16'h0000};
		ddr_reset_n = 1'b1;
	end
	// One edge per command; idle lines invert so nothing looks held
	task automatic issue(input logic [3:0] ctl, input logic [2:0] ba, input logic [15:0] a);
		cmd <= {ctl, ba, a};
		@(posedge hclk);
		cmd <= {4'hf, ~ba, ~a};
	endtask
	task automatic mode_set(input logic three, input logic [15:0] op);
		issue(4'b0000, three ? 3'b011 : 3'b000, op);
		repeat (T_MOD) @(posedge hclk);
	endtask
	// Only reads in readout mode, never writes or power-down
	task automatic readout_read(input logic bl8, input logic nib, input logic [15:0] junk);
		issue(4'b0101, junk[2:0], {junk[15:13], bl8, junk[11:3], nib, 2'b00});
	endtask
	task automatic array_op(input logic wr, input logic [15:0] a);
		issue({3'b010, !wr}, 3'h1, a);
	endtask
	task automatic exit_readout();
		repeat (T_MPRR) @(posedge hclk);
		mode_set(1'b1, 16'h0000);
	endtask
	task automatic mem_reset();
		ddr_reset_n <= 1'b0;
		@(posedge hclk);
		ddr_reset_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: ddrcr_lat_pipe.sv */
// Read latency delay line and burst beat sequencer
`timescale 1ns/1ps
`default_nettype none

module ddrcr_lat_pipe import ddrcr_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Launch from the command decoder
	input wire logic launch,
	input var ddrcr_burst_t launch_req,
	input wire logic [4:0] rl,
	// Beat output
	output logic beat_valid_q,
	output logic beat_bit_q,
	output logic busy
);

	// ==========================================================
	// Pattern lookup
	function automatic logic pattern_bit(input logic [1:0] loc, input logic [2:0] idx);
		pattern_bit = (loc == LOC_PATTERN) ? CAL_PATTERN[idx] : 1'b0;
	endfunction

	logic [PIPE_DEPTH-1:0] slot_v_q;
	ddrcr_burst_t slot_q [PIPE_DEPTH];
	logic [4:0] ins_idx;
	logic [3:0] remain_q;
	logic [2:0] idx_q;
	logic [1:0] loc_q;
	logic [2:0] start_idx;

	// Slot RL-1 reaches slot 0 after RL-1 edges, beat leaves on the RL-th
	assign ins_idx = (rl == 5'h00) ? 5'h00 : rl - 5'h01;

	// ==========================================================
	// Delay line: a shift register, so back-to-back reads never collide
	genvar i;
	generate
		for (i = 0; i < PIPE_DEPTH; i++) begin : g_slot
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					slot_v_q[i] <= 1'b0;
					slot_q[i] <= '0;
				end else if (launch && ins_idx == i[4:0]) begin
					slot_v_q[i] <= 1'b1;
					slot_q[i] <= launch_req;
				end else if (i == PIPE_DEPTH - 1) begin
					slot_v_q[i] <= 1'b0;
					slot_q[i] <= '0;
				end else begin
					slot_v_q[i] <= slot_v_q[(i + 1) % PIPE_DEPTH];
					slot_q[i] <= slot_q[(i + 1) % PIPE_DEPTH];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Beat sequencer
	assign start_idx = slot_q[0].nibble ? START_UPPER : START_LOWER;

	// A new burst takes over a running one; spacing is the controller's duty
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			remain_q <= 4'h0;
			idx_q <= 3'h0;
			loc_q <= LOC_PATTERN;
			beat_valid_q <= 1'b0;
			beat_bit_q <= 1'b0;
		end else if (slot_v_q[0]) begin
			remain_q <= (slot_q[0].chop ? BEATS_BC4 : BEATS_BL8) - 4'h1;
			idx_q <= start_idx + 3'h1;
			loc_q <= slot_q[0].loc;
			beat_valid_q <= 1'b1;
			beat_bit_q <= pattern_bit(slot_q[0].loc, start_idx);
		end else if (remain_q != 4'h0) begin
			remain_q <= remain_q - 4'h1;
			idx_q <= idx_q + 3'h1;
			beat_valid_q <= 1'b1;
			beat_bit_q <= pattern_bit(loc_q, idx_q);
		end else begin
			beat_valid_q <= 1'b0;
			beat_bit_q <= 1'b0;
		end
	end

	assign busy = (|slot_v_q) | (remain_q != 4'h0) | beat_valid_q;

endmodule

`default_nettype wire

/* File: ddrcr_pkg.sv */
// Shared types and constants of the calibration-pattern readout block
package ddrcr_pkg;

	// ==========================================================
	// Control states and decoded commands
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b01,
		ST_READOUT = 2'b10
	} ddrcr_state_t;

	typedef enum logic [3:0] {
		CMD_NOP = 4'b0001,
		CMD_MODE_SET = 4'b0010,
		CMD_READ = 4'b0100,
		CMD_WRITE = 4'b1000
	} ddrcr_cmd_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [15:0] addr;
	} ddrcr_cmd_bus_t;

	typedef struct packed {
		logic chop;
		logic nibble;
		logic [1:0] loc;
	} ddrcr_burst_t;

	// ==========================================================
	// Register map (byte addresses, low 12 bits decoded)
	localparam logic [11:0] DDRCR_ADDR_CTRL = 12'h000;
	localparam logic [11:0] DDRCR_ADDR_STATUS = 12'h004;

	localparam int CTRL_CL_LSB = 0;
	localparam int CTRL_AL_LSB = 5;
	localparam int CTRL_REPL_BIT = 7;
	localparam logic [4:0] CTRL_CL_RST = 5'h05;
	localparam logic [1:0] CTRL_AL_RST = 2'h0;
	localparam logic CTRL_REPL_RST = 1'b1;

	localparam int STAT_EN_BIT = 0;
	localparam int STAT_LOC_LSB = 1;
	localparam int STAT_BM_LSB = 3;
	localparam int STAT_BUSY_BIT = 5;
	localparam int STAT_CNT_LSB = 8;

	// ==========================================================
	// Command address fields
	localparam logic [2:0] BA_MODE_ZERO = 3'h0;
	localparam logic [2:0] BA_MODE_THREE = 3'h3;
	localparam int A_READOUT_EN = 2;
	localparam int A_LOC_LSB = 0;
	localparam int A_NIBBLE = 2;
	localparam int A_AUTOPRE = 10;
	localparam int A_BURST_CHOP = 12;
	localparam int A_BL_LSB = 0;

	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_ON_FLY = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] AL_CL_MINUS1 = 2'h1;
	localparam logic [1:0] AL_CL_MINUS2 = 2'h2;

	localparam logic [1:0] LOC_PATTERN = 2'h0;
	localparam logic [7:0] CAL_PATTERN = 8'hAA;
	localparam logic [1:0] MODE_RST = 2'h0;

	// ==========================================================
	// Burst and latency pipe
	localparam int PIPE_DEPTH = 32;
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;
	localparam logic [2:0] START_LOWER = 3'h0;
	localparam logic [2:0] START_UPPER = 3'h4;
	localparam int DQ_WIDTH = 16;
	localparam int LANES_PER_BYTE = 8;

endpackage

/* File: tb.sv */
// Self-checking bench of the calibration-pattern readout block
`timescale 1ns/1ps
`default_nettype none
module tb import ddrcr_pkg::*; ;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dq_oe, ddr_reset_n, repl;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [DQ_WIDTH-1:0] dq_out;
	ddrcr_cmd_bus_t cmd;
	int n_mismatch, n_compared, cyc, rl, cl, al, n_ro;
	int exp_c[$], got_c[$];
	logic [15:0] exp_v[$], got_v[$];
	int bm_t[6] = '{0, 1, 1, 1, 2, 3};
	logic b8_t[6] = '{1, 1, 0, 0, 0, 1};
	logic nb_t[6] = '{0, 0, 0, 1, 1, 0};
	assign hready = hreadyout;
	ddrcr_calib_readout i_ddrcr_calib_readout (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd(cmd),
		.ddr_reset_n(ddr_reset_n), .dq_out(dq_out), .dq_oe(dq_oe), .array_rd_q(),
		.array_wr_q(), .array_autopre_q(), .array_ba_q(), .array_col_q());
	ddrcr_ctrl_model i_model (.hclk(hclk), .cmd(cmd), .ddr_reset_n(ddr_reset_n));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Beats are taken mid-cycle, where the lanes have settled
	always @(negedge hclk) begin
		cyc++;
		if (dq_oe === 1'b1) begin
			got_c.push_back(cyc);
			got_v.push_back(dq_out);
		end
	end
	// ====
	// Tasks
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
		chk("bus response", 32'h0000_0000, {31'h0, hresp});
	endtask
	function automatic logic [15:0] fill(input int b);
		logic [7:0] by;
		by = repl ? {8{b[0]}} : {7'h00, b[0]};
		return {by, by};
	endfunction
	task automatic ro_read(input int loc, input logic bl8, input logic nib, input int bm);
		int base;
		base = cyc + 2 + rl;
		for (int k = 0; k < (bl8 ? 8 : 4); k++) begin
			exp_c.push_back(base + k);
			exp_v.push_back(fill((loc == 0) ? (nib * 4 + k) % 2 : 0));
		end
		n_ro++;
		// Fixed burst modes must ignore the chop bit, so it is left random there
		i_model.readout_read((bm == 1) ? bl8 : 1'($urandom), nib, 16'($urandom));
	endtask
	task automatic cmp_beats();
		chk("beat count", 32'(exp_c.size()), 32'(got_c.size()));
		while (exp_c.size() > 0 && got_c.size() > 0) begin
			chk("beat cycle", 32'(exp_c.pop_front()), 32'(got_c.pop_front()));
			chk("beat lanes", 32'(exp_v.pop_front()), 32'(got_v.pop_front()));
		end
		exp_c.delete();
		exp_v.delete();
		got_c.delete();
		got_v.delete();
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		complete_run();
	end
	// ====
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repl = 1'b1;
		rdv = $urandom(32'h806c_6626);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, DDRCR_ADDR_CTRL, 0);
		chk("ctrl reset", 32'h0000_0085, rdv);
		ahb(1'b1, DDRCR_ADDR_STATUS, 32'hffff_ffff);
		ahb(1'b0, DDRCR_ADDR_STATUS, 0);
		chk("status reset", 32'h0000_0000, rdv);
		ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_0008, 0);
		chk("unmapped", 32'h0000_0000, rdv);
		i_model.array_op(1'b1, 16'h0400);
		@(posedge hclk);
		i_model.array_op(1'b0, 16'h0008);
		for (int loc = 0; loc < 4; loc++) begin
			for (int j = 0; j < 6; j++) begin
				cl = 5 + $urandom % 6;
				al = $urandom % 3;
				repl = 1'($urandom);
				rl = cl + ((al == 1) ? cl - 1 : (al == 2) ? cl - 2 : 0);
				ahb(1'b1, DDRCR_ADDR_CTRL, {24'h0, repl, 2'(al), 5'(cl)});
				ahb(1'b0, DDRCR_ADDR_CTRL, 0);
				chk("ctrl", {24'h0, repl, 2'(al), 5'(cl)}, rdv);
				i_model.mode_set(1'b0, 16'(bm_t[j]));
				i_model.mode_set(1'b1, 16'(4 + loc));
				ro_read(loc, b8_t[j], nb_t[j], bm_t[j]);
				repeat (b8_t[j] ? 7 : 3) @(posedge hclk);
				ro_read(loc, b8_t[j], b8_t[j] ? 1'b0 : !nb_t[j], bm_t[j]);
				repeat (rl + 12) @(posedge hclk);
				cmp_beats();
				ahb(1'b0, DDRCR_ADDR_STATUS, 0);
				chk("status on", {16'h0, 8'(n_ro), 3'b000, 2'(bm_t[j]), 2'(loc), 1'b1}, rdv);
				i_model.exit_readout();
				ahb(1'b0, DDRCR_ADDR_STATUS, 0);
				chk("status off", {16'h0, 8'(n_ro), 3'b000, 2'(bm_t[j]), 3'b000}, rdv);
			end
		end
		i_model.mode_set(1'b1, 16'h0005);
		i_model.mem_reset();
		i_model.readout_read(1'b1, 1'b0, 16'h0000);
		repeat (40) @(posedge hclk);
		cmp_beats();
		ahb(1'b0, DDRCR_ADDR_STATUS, 0);
		chk("status after memory reset", 32'h0000_0000, rdv);
		complete_run();
	end
endmodule
`default_nettype wire
